// ===== design/wwd_pkg.sv
`default_nettype none
package wwd_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] OFF_CONTROL_SETTINGS = 12'h000;
  localparam logic [11:0] OFF_TIMEOUT_CONSTANT = 12'h004;
  localparam logic [11:0] OFF_RELOAD_KEY = 12'h008;
  localparam logic [11:0] OFF_COUNTER_VALUE = 12'h00c;
  localparam logic [11:0] OFF_SOURCE_SELECT = 12'h010;
  localparam logic [11:0] OFF_WARNING_COMPARE = 12'h014;
  localparam logic [11:0] OFF_EARLY_FEED_LIMIT = 12'h018;

  // ==========================================================
  // control_settings field positions
  localparam int BIT_RUN_ENABLE = 0;
  localparam int BIT_RESET_ON_TIMEOUT = 1;
  localparam int BIT_TIMEOUT_FLAG = 2;
  localparam int BIT_WARNING_FLAG = 3;
  localparam int BIT_RELOAD_GUARD = 4;
  localparam int BIT_SOURCE_LOCK = 5;
  // source_select field positions
  localparam int BIT_SOURCE = 0;
  localparam int BIT_SOURCE_WRITE_LOCK = 31;

  // ==========================================================
  // widths, reset values, keys and timing
  localparam int CNT_W = 24;
  localparam int PRESCALE_DIV = 4;
  localparam int SYNC_EDGES = 3;
  localparam logic [23:0] TC_RESET = 24'h0000ff;
  localparam logic [23:0] TC_MIN = 24'h0000ff;
  localparam logic [23:0] COUNT_RESET = 24'h0000ff;
  localparam logic [23:0] LIMIT_RESET = 24'hffffff;
  localparam logic [31:0] WARN_RESET = 32'h00000000;
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // ==========================================================
  // reload-key sequence states
  typedef enum logic [1:0] {
    FS_IDLE = 2'b01,
    FS_ARMED = 2'b10
  } wwd_feed_state_t;
endpackage : wwd_pkg
`default_nettype wire

// ===== design/wwd_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_prescaler #(
  parameter int DIV = wwd_pkg::PRESCALE_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic countClkIn,
  output logic edgePulse,
  output logic tick
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] LAST = DW'(DIV - 1);

  // ==========================================================
  // elaboration check
  if (DIV < 2) begin : g_bad_div
    $error("prescaler divide factor must be at least two");
  end

  logic prev_q;
  logic [DW-1:0] div_q;
  logic edge_q;
  logic tick_q;
  logic rise;

  // the count clock is sampled as a plain synchronous level
  assign rise = countClkIn & ~prev_q; // RULE16

  // ==========================================================
  // rising-edge detect and fixed divider
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      div_q <= '0;
      edge_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      prev_q <= countClkIn;
      edge_q <= rise;
      tick_q <= rise && (div_q == LAST); // RULE1
      if (rise) begin
        div_q <= (div_q == LAST) ? '0 : div_q + 1'b1; // RULE1
      end
    end
  end

  assign edgePulse = edge_q;
  assign tick = tick_q;
endmodule : wwd_prescaler
`default_nettype wire

// ===== design/wwd_feed_seq.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_feed_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic keyWr,
  input wire logic [7:0] keyData,
  input wire logic running,
  output logic feedDone,
  output logic feedErr
);
  wwd_pkg::wwd_feed_state_t state_q;
  logic done_q;
  logic err_q;

  // ==========================================================
  // two-byte key sequence; a wrong byte aborts and restarts
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= wwd_pkg::FS_IDLE;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      if (keyWr) begin
        case (state_q)
          wwd_pkg::FS_IDLE: begin
            if (keyData == wwd_pkg::KEY_FIRST) begin
              state_q <= wwd_pkg::FS_ARMED;
            end else begin
              err_q <= running; // RULE24
            end
          end
          wwd_pkg::FS_ARMED: begin
            state_q <= wwd_pkg::FS_IDLE;
            if (keyData == wwd_pkg::KEY_SECOND) begin
              done_q <= 1'b1; // RULE3
            end else begin
              err_q <= running; // RULE24
            end
          end
          default: state_q <= wwd_pkg::FS_IDLE;
        endcase
      end
    end
  end

  assign feedDone = done_q;
  assign feedErr = err_q;

  // ==========================================================
  // checks
  AST_KEY_PAIR_DONE: assert property (@(posedge clk) disable iff (rst) // RULE3
    (state_q == wwd_pkg::FS_ARMED) && keyWr && (keyData == wwd_pkg::KEY_SECOND)
    |=> feedDone && !feedErr)
    else $error("second key byte did not complete the feed");
  AST_KEY_ORDER_ERR: assert property (@(posedge clk) disable iff (rst) // RULE24
    (state_q == wwd_pkg::FS_IDLE) && keyWr && running && (keyData != wwd_pkg::KEY_FIRST)
    |=> feedErr && !feedDone)
    else $error("out-of-order key byte not reported");
endmodule : wwd_feed_seq
`default_nettype wire

// ===== design/wwd_top.sv
// Notes on behaviour
// (RULE1) count ticks come from the count clock divided by four; 24-bit down-counter
// (RULE2) reload never loads less than 0xff, smaller constants load 0xff
// (RULE3) key bytes 0xaa then 0x55 start the watchdog and reload the counter
// (RULE4) reaching zero without a feed raises a watchdog event
// (RULE5) with a window set, a feed above the limit is a watchdog event
// (RULE6) with reset-on-timeout set, a timeout requests a chip reset
// (RULE7) timeout flag survives a watchdog reset; software clears it
// (RULE8) warning is raised when the counter equals the warning compare value
// (RULE9) mode and constant writes reach the count logic three count-clock edges later
// (RULE10) counter is captured on the count tick, then copied for bus reads
// (RULE11) software waits three count-clock edges after a feed before setting guard
// (RULE12) source-select bit 31 set blocks writes to bit 0
// (RULE13) source lock bit freezes the source against software and power-mode changes
// (RULE14) guard bit set allows constant writes only below warning and window values
// (RULE15) source lock and reload guard clear only on a reset
// (RULE16) bus accesses and counting share the bus clock; counting paced by count clock
// (RULE17) timeout constant is 24 bits and resets to 0xff
// (RULE18) early-feed limit resets to 0xffffff so windowing is off
// (RULE19) software selects the low-power oscillator before locking the source
// (RULE20) run enable and reset-on-timeout cannot be written back to zero
// (RULE21) timeout, key error or early feed set the flag and may reset the chip
// (RULE22) mode changes are applied only by the next completed feed, except the source lock bit, which takes effect at once
// (RULE23) warning flag is set on the compare match and held until cleared
// (RULE24) a key byte out of order while running is a sequence error
`timescale 1ns/100ps
`default_nettype none
module wwd_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic wdtRst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic countClkIn,
  input wire logic autoSrcReq,
  input wire logic autoSrcSel,
  output logic chipResetReq,
  output logic warnIrq,
  output logic clkSrcSel,
  output logic clkSrcLock
);
  localparam int CW = wwd_pkg::CNT_W;
  localparam logic [1:0] SYNC_LAST = 2'(wwd_pkg::SYNC_EDGES - 1);

  // reload value with the 0xff floor applied
  function automatic logic [CW-1:0] effLoad(input logic [CW-1:0] tc);
    effLoad = (tc < wwd_pkg::TC_MIN) ? wwd_pkg::TC_MIN : tc; // RULE2
  endfunction : effLoad

  // ==========================================================
  // declarations
  logic anyRst;
  logic wrStrobe;
  logic keyWr;
  logic edgePulse;
  logic tick;
  logic feedDone;
  logic feedErr;
  logic running;
  logic earlyFeed;
  logic atZero;
  logic warnHit;
  logic wdEvent;
  logic tcWrOk;
  logic [5:0] modeBus_q;
  logic [5:0] modeSeen_q;
  logic [5:0] modeAct_q;
  logic [CW-1:0] tcBus_q;
  logic [CW-1:0] tcEff_q;
  logic [CW-1:0] limit_q;
  logic [31:0] warn_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] tvCap_q;
  logic syncPend_q;
  logic [1:0] syncCnt_q;
  logic tof_q;
  logic warnFlag_q;
  logic srcSel_q;
  logic srcWrLock_q;
  logic resetReq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // the watchdog's own reset clears everything except the timeout flag
  assign anyRst = rst | wdtRst;

  // ==========================================================
  // bus timing: zero-wait transfers, write takes effect in the access phase
  assign wrStrobe = psel & penable & pwrite & pready_q;
  assign keyWr = wrStrobe && (paddr == wwd_pkg::OFF_RELOAD_KEY);

  // ==========================================================
  // count clock pacing and reload-key sequence
  wwd_prescaler #(
    .DIV(wwd_pkg::PRESCALE_DIV)
  ) u_prescaler (
    .clk(clk),
    .rst(anyRst),
    .countClkIn(countClkIn),
    .edgePulse(edgePulse),
    .tick(tick)
  );

  wwd_feed_seq u_feed_seq (
    .clk(clk),
    .rst(anyRst),
    .keyWr(keyWr),
    .keyData(pwdata[7:0]),
    .running(running),
    .feedDone(feedDone),
    .feedErr(feedErr)
  );

  // ==========================================================
  // event decode
  assign running = modeAct_q[wwd_pkg::BIT_RUN_ENABLE];
  assign earlyFeed = feedDone && running && (count_q > limit_q); // RULE5
  assign atZero = tick && running && (count_q == '0); // RULE4
  assign warnHit = tick && running && ({8'h00, count_q} == warn_q); // RULE8
  assign wdEvent = atZero | earlyFeed | feedErr; // RULE21
  // guard: a reload value may change only once the counter is low enough
  assign tcWrOk = !modeAct_q[wwd_pkg::BIT_RELOAD_GUARD] ||
    (({8'h00, count_q} < warn_q) && (count_q < limit_q)); // RULE14

  // ==========================================================
  // mode bits on the bus side: set-once bits, no software clear
  always_ff @(posedge clk) begin
    if (anyRst) begin
      modeBus_q <= '0; // RULE15
    end else if (wrStrobe && (paddr == wwd_pkg::OFF_CONTROL_SETTINGS)) begin
      modeBus_q[wwd_pkg::BIT_RUN_ENABLE] <= modeBus_q[wwd_pkg::BIT_RUN_ENABLE] |
        pwdata[wwd_pkg::BIT_RUN_ENABLE]; // RULE20
      modeBus_q[wwd_pkg::BIT_RESET_ON_TIMEOUT] <= modeBus_q[wwd_pkg::BIT_RESET_ON_TIMEOUT] |
        pwdata[wwd_pkg::BIT_RESET_ON_TIMEOUT]; // RULE20
      modeBus_q[wwd_pkg::BIT_RELOAD_GUARD] <= modeBus_q[wwd_pkg::BIT_RELOAD_GUARD] |
        pwdata[wwd_pkg::BIT_RELOAD_GUARD]; // RULE15
      modeBus_q[wwd_pkg::BIT_SOURCE_LOCK] <= modeBus_q[wwd_pkg::BIT_SOURCE_LOCK] |
        pwdata[wwd_pkg::BIT_SOURCE_LOCK]; // RULE15
    end
  end

  // ==========================================================
  // timeout constant, window and warning compare registers
  always_ff @(posedge clk) begin
    if (anyRst) begin
      tcBus_q <= wwd_pkg::TC_RESET; // RULE17
      limit_q <= wwd_pkg::LIMIT_RESET; // RULE18
      warn_q <= wwd_pkg::WARN_RESET;
    end else if (wrStrobe) begin
      if ((paddr == wwd_pkg::OFF_TIMEOUT_CONSTANT) && tcWrOk) begin
        tcBus_q <= pwdata[CW-1:0]; // RULE14
      end
      if (paddr == wwd_pkg::OFF_EARLY_FEED_LIMIT) begin
        limit_q <= pwdata[CW-1:0];
      end
      if (paddr == wwd_pkg::OFF_WARNING_COMPARE) begin
        warn_q <= pwdata;
      end
    end
  end

  // ==========================================================
  // transfer to the count side after three count-clock edges; a fresh
  // write restarts the wait so the two halves never tear
  always_ff @(posedge clk) begin
    if (anyRst) begin
      syncPend_q <= 1'b0;
      syncCnt_q <= '0;
      tcEff_q <= wwd_pkg::TC_RESET;
      modeSeen_q <= '0;
    end else if (wrStrobe && ((paddr == wwd_pkg::OFF_CONTROL_SETTINGS) ||
                 (paddr == wwd_pkg::OFF_TIMEOUT_CONSTANT))) begin
      syncPend_q <= 1'b1;
      syncCnt_q <= '0;
    end else if (syncPend_q && edgePulse) begin
      if (syncCnt_q == SYNC_LAST) begin
        syncPend_q <= 1'b0; // RULE9
        syncCnt_q <= '0;
        tcEff_q <= tcBus_q; // RULE9
        modeSeen_q <= modeBus_q; // RULE9
      end else begin
        syncCnt_q <= syncCnt_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // active mode: only a completed feed adopts the delivered mode bits
  always_ff @(posedge clk) begin
    if (anyRst) begin
      modeAct_q <= '0;
    end else if (feedDone && !earlyFeed) begin
      modeAct_q <= modeSeen_q; // RULE22 RULE3
    end
  end

  // ==========================================================
  // down-counter; after a timeout it reloads and keeps running
  always_ff @(posedge clk) begin
    if (anyRst) begin
      count_q <= wwd_pkg::COUNT_RESET;
    end else if (feedDone && !earlyFeed) begin
      count_q <= effLoad(tcEff_q); // RULE3 RULE2
    end else if (tick && running) begin
      if (count_q == '0) begin
        count_q <= effLoad(tcEff_q); // RULE2
      end else begin
        count_q <= count_q - 1'b1; // RULE1
      end
    end
  end

  // capture on the count tick or a completed key pair; the bus read copies this snapshot
  always_ff @(posedge clk) begin
    if (anyRst) begin
      tvCap_q <= wwd_pkg::COUNT_RESET;
    end else if (tick || feedDone) begin
      tvCap_q <= count_q; // RULE10
    end
  end

  // ==========================================================
  // timeout flag: only an external reset clears it in hardware, so it
  // still tells software why the chip restarted; set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      tof_q <= 1'b0;
    end else if (wdEvent) begin
      tof_q <= 1'b1; // RULE21 RULE4
    end else if (wrStrobe && (paddr == wwd_pkg::OFF_CONTROL_SETTINGS) &&
                 !pwdata[wwd_pkg::BIT_TIMEOUT_FLAG]) begin
      tof_q <= 1'b0; // RULE7
    end
  end

  // warning flag, write one to clear, set beats clear
  always_ff @(posedge clk) begin
    if (anyRst) begin
      warnFlag_q <= 1'b0;
    end else if (warnHit) begin
      warnFlag_q <= 1'b1; // RULE23 RULE8
    end else if (wrStrobe && (paddr == wwd_pkg::OFF_CONTROL_SETTINGS) &&
                 pwdata[wwd_pkg::BIT_WARNING_FLAG]) begin
      warnFlag_q <= 1'b0; // RULE23
    end
  end

  // chip reset request holds until the watchdog reset comes back
  always_ff @(posedge clk) begin
    if (anyRst) begin
      resetReq_q <= 1'b0;
    end else if (wdEvent && modeAct_q[wwd_pkg::BIT_RESET_ON_TIMEOUT]) begin
      resetReq_q <= 1'b1; // RULE6 RULE21
    end
  end

  // ==========================================================
  // count clock source select and its locks
  always_ff @(posedge clk) begin
    if (anyRst) begin
      srcSel_q <= 1'b0;
      srcWrLock_q <= 1'b0;
    end else begin
      if (wrStrobe && (paddr == wwd_pkg::OFF_SOURCE_SELECT)) begin
        srcWrLock_q <= srcWrLock_q | pwdata[wwd_pkg::BIT_SOURCE_WRITE_LOCK];
        if (!srcWrLock_q && !modeBus_q[wwd_pkg::BIT_SOURCE_LOCK]) begin
          srcSel_q <= pwdata[wwd_pkg::BIT_SOURCE]; // RULE12 RULE13
        end
      end else if (autoSrcReq && !modeBus_q[wwd_pkg::BIT_SOURCE_LOCK]) begin
        srcSel_q <= autoSrcSel; // RULE13
      end
    end
  end

  // ==========================================================
  // bus read data, ready and error; decoded in the setup phase
  always_ff @(posedge clk) begin
    if (anyRst) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= 1'b0;
      if (psel && !penable) begin
        prdata_q <= '0;
        case (paddr)
          wwd_pkg::OFF_CONTROL_SETTINGS: begin
            prdata_q <= {26'h0000000, modeBus_q[5:4], warnFlag_q, tof_q, modeBus_q[1:0]};
          end
          wwd_pkg::OFF_TIMEOUT_CONSTANT: prdata_q <= {8'h00, tcBus_q};
          wwd_pkg::OFF_RELOAD_KEY: prdata_q <= '0; // write-only
          wwd_pkg::OFF_COUNTER_VALUE: prdata_q <= {8'h00, tvCap_q}; // RULE10
          wwd_pkg::OFF_SOURCE_SELECT: prdata_q <= {srcWrLock_q, 30'h00000000, srcSel_q};
          wwd_pkg::OFF_WARNING_COMPARE: prdata_q <= warn_q;
          wwd_pkg::OFF_EARLY_FEED_LIMIT: prdata_q <= {8'h00, limit_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign chipResetReq = resetReq_q;
  assign warnIrq = warnFlag_q;
  assign clkSrcSel = srcSel_q;
  assign clkSrcLock = modeBus_q[wwd_pkg::BIT_SOURCE_LOCK];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (anyRst);

  sequence sTickAtZero;
    tick && running && (count_q == '0);
  endsequence
  sequence sGoodFeed;
    feedDone && !earlyFeed;
  endsequence

  AST_DECREMENT: assert property ( // RULE1
    tick && running && (count_q != '0) && !feedDone |=> count_q == $past(count_q) - 1'b1)
    else $error("counter did not step down by one on a tick");
  AST_LOAD_FLOOR: assert property ( // RULE2
    sGoodFeed |=> (count_q >= wwd_pkg::TC_MIN) && (count_q == effLoad($past(tcEff_q))))
    else $error("feed loaded a value below the floor");
  AST_ZERO_EVENT: assert property ( // RULE4
    sTickAtZero |=> tof_q && (count_q >= wwd_pkg::TC_MIN))
    else $error("timeout at zero did not set the flag");
  AST_EARLY_EVENT: assert property ( // RULE5
    earlyFeed |=> tof_q && ($stable(count_q) || $past(tick)))
    else $error("early feed not treated as an event");
  AST_RESET_REQ: assert property ( // RULE6
    sTickAtZero ##0 modeAct_q[wwd_pkg::BIT_RESET_ON_TIMEOUT] |=> chipResetReq[*3])
    else $error("timeout did not hold the chip reset request");
  AST_WARN_SET: assert property ( // RULE8
    warnHit |=> warnIrq)
    else $error("warning match did not raise the warning");
  AST_SYNC_DELAY: assert property ( // RULE9
    !wrStrobe && syncPend_q && edgePulse && (syncCnt_q == SYNC_LAST) |=> !syncPend_q &&
      (tcEff_q == $past(tcBus_q)))
    else $error("constant not delivered on the third count edge");
  AST_SRC_FROZEN: assert property ( // RULE12
    (srcWrLock_q && !autoSrcReq) || clkSrcLock |=> $stable(clkSrcSel))
    else $error("locked clock source changed");
  AST_STICKY_MODE: assert property ( // RULE20
    modeBus_q[wwd_pkg::BIT_RUN_ENABLE] |=> modeBus_q[wwd_pkg::BIT_RUN_ENABLE][*2])
    else $error("run enable was cleared by software");
endmodule : wwd_top
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, wdtRst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdat;
  logic pready, pslverr, countClkIn = 1'b0, autoSrcReq = 1'b0, autoSrcSel = 1'b0;
  logic chipResetReq, warnIrq, clkSrcSel, clkSrcLock, lastErr;
  int errorCnt = 0, comparisons = 0, cyc = 0, n;
  logic [23:0] c1, c2;

  wwd_top wwd_top_i (.clk(clk), .rst(rst), .wdtRst(wdtRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countClkIn(countClkIn), .autoSrcReq(autoSrcReq),
    .autoSrcSel(autoSrcSel), .chipResetReq(chipResetReq), .warnIrq(warnIrq),
    .clkSrcSel(clkSrcSel), .clkSrcLock(clkSrcLock));

  // ==========================================================
  // clocks and hang guard
  initial begin
    forever #2.5 clk = ~clk;
  end
  // count clock free-runs at half the bus rate, so one tick per eight cycles
  always @(posedge clk) begin
    countClkIn <= ~countClkIn;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt = errorCnt + 1;
      stopTest();
    end
  end

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errorCnt = errorCnt + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one setup cycle, then access held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8 && pready !== 1'b1; i++) @(posedge clk);
    rdat = prdata;
    lastErr = pslverr;
    chk(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // the write lands at the access edge; one more edge before outputs are looked at
    @(posedge clk);
  endtask : wr
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rdat & m, e);
  endtask : rdm
  task automatic feed();
    wr(wwd_pkg::OFF_RELOAD_KEY, 32'h000000aa);
    wr(wwd_pkg::OFF_RELOAD_KEY, 32'h00000055);
  endtask : feed
  task automatic pulse(input logic ext);
    @(posedge clk);
    if (ext) rst <= 1'b1;
    else wdtRst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wdtRst <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // ==========================================================
  // scenarios
  task automatic s_reset();
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'hffffffff, 32'h00000000);
    rdm(wwd_pkg::OFF_TIMEOUT_CONSTANT, 32'hffffffff, 32'h000000ff);
    rdm(wwd_pkg::OFF_COUNTER_VALUE, 32'hffffffff, 32'h000000ff);
    rdm(wwd_pkg::OFF_EARLY_FEED_LIMIT, 32'hffffffff, 32'h00ffffff);
    rdm(wwd_pkg::OFF_WARNING_COMPARE, 32'hffffffff, 32'h00000000);
    rdm(12'h040, 32'hffffffff, 32'h00000000);
    chk(lastErr, 1'b1);
    $display("test reset done");
  endtask : s_reset

  task automatic s_run();
    wr(wwd_pkg::OFF_TIMEOUT_CONSTANT, 32'h00000010);
    wr(wwd_pkg::OFF_WARNING_COMPARE, 32'h000000f8);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000003);
    repeat (40) @(posedge clk);
    feed();
    chk(warnIrq, 1'b0);
    repeat (16) @(posedge clk);
    rdm(wwd_pkg::OFF_COUNTER_VALUE, 32'hffffff00, 32'h00000000);
    chk(rdat[7:0] >= 8'hf0, 1'b1);
    c1 = rdat[23:0];
    repeat (80) @(posedge clk);
    apb(1'b0, wwd_pkg::OFF_COUNTER_VALUE, 32'h00000000);
    c2 = rdat[23:0];
    chk((c1 - c2 >= 24'd9) && (c1 - c2 <= 24'd11), 1'b1);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000000);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000003, 32'h00000003);
    for (n = 0; n < 200 && warnIrq !== 1'b1; n++) @(posedge clk);
    chk(warnIrq, 1'b1);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000008, 32'h00000008);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h0000000b);
    repeat (2) @(posedge clk);
    chk(warnIrq, 1'b0);
    chk(chipResetReq, 1'b0);
    for (n = 0; n < 2500 && chipResetReq !== 1'b1; n++) @(posedge clk);
    chk(chipResetReq, 1'b1);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000004, 32'h00000004);
    pulse(1'b0);
    chk(chipResetReq, 1'b0);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000007, 32'h00000004);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000000);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000004, 32'h00000000);
    $display("test run done");
  endtask : s_run

  task automatic s_errs();
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000001);
    repeat (40) @(posedge clk);
    feed();
    wr(wwd_pkg::OFF_RELOAD_KEY, 32'h00000012);
    repeat (4) @(posedge clk);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000004, 32'h00000004);
    chk(chipResetReq, 1'b0);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000001);
    wr(wwd_pkg::OFF_EARLY_FEED_LIMIT, 32'h00000080);
    repeat (40) @(posedge clk);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000004, 32'h00000000);
    feed();
    repeat (4) @(posedge clk);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000004, 32'h00000004);
    $display("test errors done");
  endtask : s_errs

  task automatic s_lock();
    pulse(1'b1);
    wr(wwd_pkg::OFF_SOURCE_SELECT, 32'h00000001);
    chk(clkSrcSel, 1'b1);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000020);
    chk(clkSrcLock, 1'b1);
    @(posedge clk);
    autoSrcReq <= 1'b1;
    @(posedge clk);
    autoSrcReq <= 1'b0;
    repeat (3) @(posedge clk);
    chk(clkSrcSel, 1'b1);
    wr(wwd_pkg::OFF_SOURCE_SELECT, 32'h00000000);
    rdm(wwd_pkg::OFF_SOURCE_SELECT, 32'h00000001, 32'h00000001);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000000);
    chk(clkSrcLock, 1'b1);
    pulse(1'b1);
    chk({clkSrcLock, clkSrcSel}, 2'b00);
    wr(wwd_pkg::OFF_SOURCE_SELECT, 32'h80000001);
    wr(wwd_pkg::OFF_SOURCE_SELECT, 32'h00000000);
    rdm(wwd_pkg::OFF_SOURCE_SELECT, 32'h80000001, 32'h80000001);
    chk(clkSrcSel, 1'b1);
    $display("test lock done");
  endtask : s_lock

  task automatic s_guard();
    pulse(1'b1);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000011);
    repeat (40) @(posedge clk);
    feed();
    repeat (40) @(posedge clk);
    wr(wwd_pkg::OFF_TIMEOUT_CONSTANT, 32'h00001234);
    rdm(wwd_pkg::OFF_TIMEOUT_CONSTANT, 32'hffffffff, 32'h000000ff);
    wr(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000000);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000010, 32'h00000010);
    pulse(1'b1);
    rdm(wwd_pkg::OFF_CONTROL_SETTINGS, 32'h00000010, 32'h00000000);
    $display("test guard done");
  endtask : s_guard

  // ==========================================================
  // closing report, the single exit of the run
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stopTest

  // reset held two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_run();
    s_errs();
    s_lock();
    s_guard();
    stopTest();
  end
endmodule : tb
`default_nettype wire
